// File: bench/spi_host.sv
// three-wire host: sclk idles low, data changes after each falling edge
module spi_host (
   output logic      cs_b,
   output logic      sclk,
   output logic      sio_in,
   input  wire logic sio_out,
   input  wire logic sio_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv;
   logic d;
   //////////////////////////////////////////////////
   // line level: device drive, host drive, or a released line that flips
   assign sio_in = sio_oe ? sio_out : (drv ? d : ~d);
   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      drv  = 1'b0;
      d    = 1'b0;
   end
   // one 24-bit frame at a 160 ns serial period, then cs_b high for 100 ns
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
      logic [23:0] sh;
      sh   = {cmd, wd};
      rd   = 16'h0000;
      cs_b = 1'b0;
      drv  = 1'b1;
      for (int i = 23; i >= 0; i--) begin
         d = sh[i];
         if (i < 16 && cmd[7]) begin
            drv = 1'b0; // host lets go while the device answers
         end
         #80 sclk = 1'b1;
         if (i < 16) begin
            rd[i] = sio_in;
         end
         #80 sclk = 1'b0;
      end
      #80 cs_b = 1'b1;
      drv = 1'b0;
      #100;
   endtask : xfer
endmodule : spi_host

// File: bench/tb.sv
module tb;
   import temp_cfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys, rst_b, sclk, cs_b, sio, sio_out, sio_oe;
   logic              adc_start, adc_valid, slew_event, crc_error, alert_b;
   logic [TEMP_W-1:0] smp;
   logic [15:0]       thigh, rd;
   int                n_errors, compares, n_conv, cyc;
   //////////////////////////////////////////////////
   temp_sensor_config_alert_ctrl #(.SRST_CYC_P(20), .PERIOD_CYC_P({8{32'd400}})) dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_b(cs_b),
      .spi_sio_in(sio), .spi_sio_out(sio_out), .spi_sio_oe(sio_oe),
      .adc_start(adc_start), .adc_valid(adc_valid), .adc_sample(smp),
      .thigh_limit(thigh), .hyst_cfg(16'h0A0A), .slew_pos_status(1'b0),
      .slew_event(slew_event), .crc_error(crc_error), .alert_b(alert_b));
   spi_host host (.cs_b(cs_b), .sclk(sclk), .sio_in(sio), .sio_out(sio_out), .sio_oe(sio_oe));
   //////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // converter answers each start one half cycle later; starts are counted
   always @(negedge clk_sys) begin
      adc_valid <= adc_start;
      if (adc_start === 1'b1) n_conv++;
   end
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_errors++;
         final_report();
      end
   end
   //////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
      host.xfer({1'b1, a}, 16'h0000, rd);
      check(rd, exp);
   endtask : rdc
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      host.xfer({1'b0, a}, v, rd);
   endtask : wr
   task automatic wait_alert;
      for (int i = 0; i < 3000 && alert_b !== 1'b0; i++) @(negedge clk_sys);
   endtask : wait_alert
   task automatic pulse(input int k);
      @(negedge clk_sys);
      if (k == 0) crc_error = 1'b1;
      else slew_event = 1'b1;
      @(negedge clk_sys);
      crc_error  = 1'b0;
      slew_event = 1'b0;
   endtask : pulse
   task automatic test_end(input string s);
      $display("test %s done, errors %0d", s, n_errors);
   endtask : test_end
   task automatic final_report;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   //////////////////////////////////////////////////
   // main sequence
   initial begin
      {n_errors, compares, n_conv, cyc} = '0;
      {rst_b, slew_event, crc_error} = '0;
      smp   = '0;
      thigh = 16'h2A80;
      repeat (16) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      rdc(7'h03, 16'h0006);
      rdc(7'h04, 16'h0016);
      rdc(7'h05, 16'hF380);
      test_end("reset values");
      wr(7'h03, 16'h0008);
      n_conv = 0;
      wr(7'h03, 16'h00FF);
      repeat (200) @(negedge clk_sys);
      check(16'(n_conv), 16'h0008);
      rdc(7'h03, 16'h00AF);
      wr(7'h05, 16'hFFFF);
      rdc(7'h05, 16'hFFFC);
      test_end("control fields");
      wr(7'h03, 16'h0100);
      rdc(7'h03, 16'h0006);
      rdc(7'h05, 16'hF380);
      test_end("soft reset");
      wr(7'h03, 16'h0008);
      host.xfer(8'h82, 16'h0000, rd);
      wr(7'h04, 16'h0001);
      n_conv = 0;
      wr(7'h03, 16'h0018);
      wait_alert();
      check(16'(alert_b), 16'h0000);
      check(16'(n_conv), 16'h0001);
      wr(7'h04, 16'h0000);
      check(16'(alert_b), 16'h0000);
      rdc(7'h02, 16'h0001);
      check(16'(alert_b), 16'h0001);
      rdc(7'h02, 16'h0000);
      test_end("data ready alert");
      smp = 14'h0B00;
      wr(7'h04, 16'h0004);
      wr(7'h03, 16'h0038);
      wait_alert();
      check(16'(alert_b), 16'h0000);
      rdc(7'h02, 16'h0015);
      check(16'(alert_b), 16'h0000);
      test_end("comparator high");
      wr(7'h03, 16'h0008);
      for (int k = 0; k < 2; k++) begin
         host.xfer(8'h82, 16'h0000, rd);
         wr(7'h04, (k == 0) ? 16'h0010 : 16'h0008);
         pulse(k);
         wait_alert();
         check(16'(alert_b), 16'h0000);
         host.xfer(8'h82, 16'h0000, rd);
         check(16'(alert_b), 16'h0001);
      end
      rdc(7'h10, 16'h0000);
      test_end("checksum and slew");
      final_report();
   end
endmodule : tb

// File: src/conv_seq.sv
module conv_seq
   import temp_cfg_pkg::*;
#(
   parameter int unsigned      SRST_CYC_P   = SRST_CYC,
   parameter logic [7:0][31:0] PERIOD_CYC_P = period_cycles()
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              continuous,
   input  wire logic              avg_en,
   input  wire logic [2:0]        period_sel,
   input  wire logic              oneshot_go,
   input  wire logic              srst_go,
   input  wire logic              smp_valid,
   input  wire logic [TEMP_W-1:0] smp,
   output logic                   conv_start,
   output logic                   res_valid,
   output logic [TEMP_W-1:0]      res,
   output logic                   oneshot_done,
   output logic                   srst_busy
);
   seq_state_t              st_q, st_d;
   logic [31:0]             cnt_q, cnt_d, cnt_dec;
   logic [2:0]              nsmp_q, nsmp_d;
   logic signed [16:0]      acc_q, acc_d, sum;
   logic                    os_q, os_d, start_q, start_d, rv_q, rv_d, osd_q, osd_d, go;
   logic [TEMP_W-1:0]       res_q, res_d;

   //////////////////////////////////////////////////////////////////////////
   // conversion pacing, averaging and soft reset timing
   always_comb begin
      st_d    = st_q;
      cnt_dec = (cnt_q == 32'h0) ? 32'h0 : cnt_q - 32'h1;
      cnt_d   = cnt_dec;
      nsmp_d  = nsmp_q;
      acc_d   = acc_q;
      os_d    = os_q;
      res_d   = res_q;
      start_d = 1'b0;
      rv_d    = 1'b0;
      osd_d   = 1'b0;
      go      = 1'b0;
      sum     = acc_q + {{3{smp[TEMP_W-1]}}, smp};
      unique case (st_q)
         SQ_IDLE: go = oneshot_go | continuous;
         SQ_CONV: begin
            if (smp_valid) begin
               if (!avg_en || nsmp_q == 3'h7) begin
                  rv_d  = 1'b1;
                  res_d = avg_en ? sum[16:3] : smp;
                  osd_d = os_q;
                  st_d  = SQ_WAIT;
               end else begin
                  acc_d   = sum;
                  nsmp_d  = nsmp_q + 3'h1;
                  start_d = 1'b1;
               end
            end
         end
         SQ_WAIT: begin
            if (oneshot_go) go = 1'b1;
            else if (!continuous || os_q) st_d = SQ_IDLE;
            else if (cnt_q == 32'h0) go = 1'b1;
         end
         SQ_SRST: begin
            if (cnt_q == 32'h0) st_d = SQ_IDLE;
         end
      endcase
      if (go) begin
         st_d    = SQ_CONV;
         start_d = 1'b1;
         acc_d   = '0;
         nsmp_d  = '0;
         os_d    = oneshot_go;
         cnt_d   = PERIOD_CYC_P[period_sel] - 32'h1;
      end
      if (srst_go) begin
         st_d    = SQ_SRST;
         cnt_d   = SRST_CYC_P - 32'h1;
         start_d = 1'b0;
         rv_d    = 1'b0;
         osd_d   = 1'b0;
      end
   end

   // state registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q    <= SQ_IDLE;
         cnt_q   <= '0;
         nsmp_q  <= '0;
         acc_q   <= '0;
         os_q    <= 1'b0;
         res_q   <= '0;
         start_q <= 1'b0;
         rv_q    <= 1'b0;
         osd_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         nsmp_q  <= nsmp_d;
         acc_q   <= acc_d;
         os_q    <= os_d;
         res_q   <= res_d;
         start_q <= start_d;
         rv_q    <= rv_d;
         osd_q   <= osd_d;
      end
   end

   assign conv_start   = start_q;
   assign res_valid    = rv_q;
   assign res          = res_q;
   assign oneshot_done = osd_q;
   assign srst_busy    = (st_q == SQ_SRST);

   property p_srst_len;
      @(posedge clk_sys) disable iff (!rst_b)
      srst_go |=> st_q == SQ_SRST && cnt_q == SRST_CYC_P - 32'h1;
   endproperty
   a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");

   property p_avg_eight;
      @(posedge clk_sys) disable iff (!rst_b)
      st_q == SQ_CONV && smp_valid && avg_en && nsmp_q != 3'h7 && !srst_go
         |=> !rv_q ##0 conv_start;
   endproperty
   a_avg_eight: assert property (p_avg_eight) else $error("average ended early");
endmodule : conv_seq

// File: src/spi_link.sv
module spi_link
   import temp_cfg_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        sclk,
   input  wire logic        cs_b,
   input  wire logic        sio_in,
   input  wire logic [15:0] rd_data,
   output reg_req_t         req,
   output logic             sio_out,
   output logic             sio_oe
);
   logic [2:0]  sclk_s, cs_s, sio_s;
   logic [4:0]  cnt_q, cnt_d;
   logic [22:0] sh_q, sh_d;
   logic [15:0] tx_q, tx_d;
   logic        rdf_q, rdf_d, oe_q, oe_d;
   reg_req_t    req_q, req_d;
   logic        rise, fall;

   //////////////////////////////////////////////////////////////////////////
   // frame decode: sample on rising sclk, drive read data on falling sclk
   always_comb begin
      rise  = sclk_s[1] & ~sclk_s[2];
      fall  = ~sclk_s[1] & sclk_s[2];
      cnt_d = cnt_q;
      sh_d  = sh_q;
      tx_d  = tx_q;
      rdf_d = rdf_q;
      oe_d  = oe_q;
      req_d = '0;
      if (cs_s[1]) begin
         cnt_d = '0;
         rdf_d = 1'b0;
         oe_d  = 1'b0;
      end else begin
         if (rise && cnt_q < 5'(FRAME_BITS)) begin
            sh_d  = {sh_q[21:0], sio_s[1]};
            cnt_d = cnt_q + 5'd1;
            if (cnt_q == 5'(CMD_BITS - 1) && sh_q[B_RD - 1]) begin
               rdf_d      = 1'b1;
               req_d.rd   = 1'b1;
               req_d.addr = {sh_q[5:0], sio_s[1]};
            end
            if (cnt_q == 5'(FRAME_BITS - 1) && !rdf_q) begin
               req_d.wr    = 1'b1;
               req_d.addr  = sh_q[21:15];
               req_d.wdata = {sh_q[14:0], sio_s[1]};
            end
         end
         if (fall && rdf_q && cnt_q >= 5'(CMD_BITS)) begin
            tx_d = (cnt_q == 5'(CMD_BITS)) ? rd_data : {tx_q[14:0], 1'b0};
            oe_d = 1'b1;
         end
      end
   end

   // pins pass two flops before use; bit 2 keeps edge history
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_s <= '0;
         cs_s   <= 3'h7;
         sio_s  <= '0;
         cnt_q  <= '0;
         sh_q   <= '0;
         tx_q   <= '0;
         rdf_q  <= 1'b0;
         oe_q   <= 1'b0;
         req_q  <= '0;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk};
         cs_s   <= {cs_s[1:0], cs_b};
         sio_s  <= {sio_s[1:0], sio_in};
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         tx_q   <= tx_d;
         rdf_q  <= rdf_d;
         oe_q   <= oe_d;
         req_q  <= req_d;
      end
   end

   assign req     = req_q;
   assign sio_out = tx_q[15];
   assign sio_oe  = oe_q;
endmodule : spi_link

// File: src/temp_cfg_pkg.sv
// Notes on behaviour
// - writing one to the soft reset bit runs a 0.5 ms internal reset
// - the soft reset bit always reads back as zero
// - averaging enabled makes every result, one-shot too, a mean of eight conversions
// - alert mode bit picks interrupt behaviour at zero, comparator behaviour at one
// - one-shot trigger runs one conversion, or eight with averaging, then the device enters shutdown; a trigger written while a conversion runs is ignored
// - the one-shot trigger bit always reads back as zero
// - conversion mode bit zero runs continuously, one shuts periodic conversions down
// - three-bit interval code picks 6 ms up to 2 s, reset code 110b
// - a flag drives the alert pin only while its enable bit is one
// - status flags still set while their alert enable is zero
// - an asserted alert holds until status read or new conversion, despite disable
// - enable bit 4 gates the checksum error flag, resets to one
// - enable bit 3 gates slew flag or live slew status, resets to zero
// - enable bit 2 gates high flag or high status, resets to one
// - enable bit 1 gates low flag or low status, resets to one
// - enable bit 0 gates the data-ready flag, resets to zero
// - low threshold is 14-bit two's complement in bits 15 to 2
// - both limits are ignored while high threshold is not above low threshold
// - low threshold bits 1 and 0 always read as zero
// - low threshold resets to F380h, minus 25 degrees
// - in interrupt mode one status read clears the latched flags
// - high status sets above high limit, clears below limit minus hysteresis
// - data-ready sets on a new result, clears on status or result read
package temp_cfg_pkg;
   // register map
   localparam logic [6:0]  ADDR_RESULT = 7'h00;
   localparam logic [6:0]  ADDR_STATUS = 7'h02;
   localparam logic [6:0]  ADDR_CONV   = 7'h03;
   localparam logic [6:0]  ADDR_IRQEN  = 7'h04;
   localparam logic [6:0]  ADDR_TLOW   = 7'h05;
   localparam int          B_SRST      = 8;
   localparam int          B_AVG       = 7;
   localparam int          B_CMP       = 5;
   localparam int          B_ONESHOT   = 4;
   localparam int          B_SHUTDOWN  = 3;
   localparam logic [15:0] CONV_RST    = 16'h0006;
   localparam logic [15:0] IRQEN_RST   = 16'h0016;
   localparam logic [15:0] TLOW_RST    = 16'hF380;
   localparam logic [15:0] CONV_WMASK  = 16'h00AF;
   localparam logic [15:0] IRQEN_WMASK = 16'h001F;
   localparam logic [15:0] TLOW_WMASK  = 16'hFFFC;
   // serial frame: read bit and 7-bit address, then 16 data bits, msb first
   localparam int          CMD_BITS    = 8;
   localparam int          FRAME_BITS  = 24;
   localparam int          B_RD        = 7;
   localparam int          TEMP_W      = 14;
   // timing
   localparam int unsigned CLK_MHZ      = 200;
   localparam int unsigned SRST_TIME_US = 500;
   localparam int unsigned SRST_CYC     = SRST_TIME_US * CLK_MHZ;
   localparam int unsigned PERIOD_US [8] = '{6000, 31250, 62500, 125000,
                                            250000, 500000, 1000000, 2000000};

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef enum logic [3:0] {
      SQ_IDLE = 4'b0001,
      SQ_CONV = 4'b0010,
      SQ_WAIT = 4'b0100,
      SQ_SRST = 4'b1000
   } seq_state_t;

   // conversion interval in clock cycles, indexed by interval code
   function automatic logic [7:0][31:0] period_cycles();
      logic [7:0][31:0] p;
      for (int i = 0; i < 8; i++) begin
         p[i] = 32'(PERIOD_US[i] * CLK_MHZ);
      end
      return p;
   endfunction : period_cycles
endpackage : temp_cfg_pkg

// File: src/temp_sensor_config_alert_ctrl.sv
module temp_sensor_config_alert_ctrl
   import temp_cfg_pkg::*;
#(
   parameter int unsigned      SRST_CYC_P   = SRST_CYC,
   parameter logic [7:0][31:0] PERIOD_CYC_P = period_cycles()
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              spi_sclk,
   input  wire logic              spi_cs_b,
   input  wire logic              spi_sio_in,
   output logic                   spi_sio_out,
   output logic                   spi_sio_oe,
   output logic                   adc_start,
   input  wire logic              adc_valid,
   input  wire logic [TEMP_W-1:0] adc_sample,
   input  wire logic [15:0]       thigh_limit,
   input  wire logic [15:0]       hyst_cfg,
   input  wire logic              slew_pos_status,
   input  wire logic              slew_event,
   input  wire logic              crc_error,
   output logic                   alert_b
);
   if (SRST_CYC_P < 1) begin : g_chk
      $error("SRST_CYC_P must be at least one");
   end

   reg_req_t          req;
   logic [15:0]       rd_data_q, rd_data_d;
   logic [15:0]       conv_q, conv_d, en_q, en_d, tlow_q, tlow_d;
   logic              dr_q, dr_d, lo_f_q, lo_f_d, hi_f_q, hi_f_d;
   logic              sl_f_q, sl_f_d, crc_f_q, crc_f_d;
   logic              lo_st_q, lo_st_d, hi_st_q, hi_st_d;
   logic              alert_b_q, alert_b_d;
   logic              wr_ok, st_rd, res_rd, srst_go, oneshot_go, limits_ok, src;
   logic              res_valid, oneshot_done, srst_busy;
   logic [TEMP_W-1:0] res;
   logic [15:0]       temp16;
   logic [15:0]       status_v;

   // widen a 16-bit two's complement value for compare and offset math
   function automatic logic signed [17:0] sx(input logic [15:0] v);
      return {{2{v[15]}}, v};
   endfunction : sx

   // hysteresis of 0.5 degree steps in the 16-bit limit format
   function automatic logic signed [17:0] hy(input logic [7:0] h);
      return {4'h0, h, 6'h00};
   endfunction : hy

   //////////////////////////////////////////////////////////////////////////
   // serial register port and conversion pacing
   spi_link u_link (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .sclk    (spi_sclk),
      .cs_b    (spi_cs_b),
      .sio_in  (spi_sio_in),
      .rd_data (rd_data_q),
      .req     (req),
      .sio_out (spi_sio_out),
      .sio_oe  (spi_sio_oe)
   );

   conv_seq #(
      .SRST_CYC_P   (SRST_CYC_P),
      .PERIOD_CYC_P (PERIOD_CYC_P)
   ) u_seq (
      .clk_sys      (clk_sys),
      .rst_b        (rst_b),
      .continuous   (!conv_q[B_SHUTDOWN]),
      .avg_en       (conv_q[B_AVG]),
      .period_sel   (conv_q[2:0]),
      .oneshot_go   (oneshot_go),
      .srst_go      (srst_go),
      .smp_valid    (adc_valid),
      .smp          (adc_sample),
      .conv_start   (adc_start),
      .res_valid    (res_valid),
      .res          (res),
      .oneshot_done (oneshot_done),
      .srst_busy    (srst_busy)
   );

   //////////////////////////////////////////////////////////////////////////
   // access strobes and derived values
   always_comb begin
      wr_ok      = req.wr && !srst_busy;
      st_rd      = req.rd && req.addr == ADDR_STATUS;
      res_rd     = req.rd && req.addr == ADDR_RESULT;
      srst_go    = wr_ok && req.addr == ADDR_CONV && req.wdata[B_SRST];
      oneshot_go = wr_ok && req.addr == ADDR_CONV && req.wdata[B_ONESHOT];
      temp16     = {res, 2'b00};
      limits_ok  = sx(thigh_limit) > sx(tlow_q);
      status_v   = {8'h00, crc_f_q, slew_pos_status, sl_f_q, hi_st_q,
                    lo_st_q, hi_f_q, lo_f_q, dr_q};
      if (conv_q[B_CMP]) begin
         src = (en_q[4] & crc_f_q) | (en_q[3] & slew_pos_status) |
               (en_q[2] & hi_st_q) | (en_q[1] & lo_st_q) |
               (en_q[0] & dr_q);
      end else begin
         src = (en_q[4] & crc_f_q) | (en_q[3] & sl_f_q) |
               (en_q[2] & hi_f_q) | (en_q[1] & lo_f_q) |
               (en_q[0] & dr_q);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // registers, flags, alert pin and read data: next values
   always_comb begin
      conv_d    = conv_q;
      en_d      = en_q;
      tlow_d    = tlow_q;
      lo_st_d   = lo_st_q;
      hi_st_d   = hi_st_q;
      rd_data_d = rd_data_q;
      // register writes; reserved bits are masked away
      if (wr_ok) begin
         unique case (req.addr)
            ADDR_CONV:  conv_d = req.wdata & CONV_WMASK;
            ADDR_IRQEN: en_d   = req.wdata & IRQEN_WMASK;
            ADDR_TLOW:  tlow_d = req.wdata & TLOW_WMASK;
            default:    ;
         endcase
      end
      if (oneshot_done) conv_d[B_SHUTDOWN] = 1'b1;
      // limit compare with hysteresis, skipped while limits are misordered
      if (res_valid && limits_ok) begin
         if (sx(temp16) > sx(thigh_limit)) hi_st_d = 1'b1;
         else if (sx(temp16) < sx(thigh_limit) - hy(hyst_cfg[15:8])) hi_st_d = 1'b0;
         if (sx(temp16) < sx(tlow_q)) lo_st_d = 1'b1;
         else if (sx(temp16) > sx(tlow_q) + hy(hyst_cfg[7:0])) lo_st_d = 1'b0;
      end
      // latched flags set regardless of enables; a set beats a read clear
      dr_d    = (dr_q & ~(st_rd | res_rd)) | res_valid;
      crc_f_d = (crc_f_q & ~st_rd) | crc_error;
      sl_f_d  = (sl_f_q & ~st_rd) | slew_event;
      hi_f_d  = (hi_f_q & ~st_rd) | (hi_st_d ^ hi_st_q);
      lo_f_d  = (lo_f_q & ~st_rd) | (lo_st_d ^ lo_st_q);
      // an asserted pin holds until status read or new conversion
      // in interrupt mode a status read masks the latched sources that it clears
      alert_b_d = ~((src & ~(st_rd & ~conv_q[B_CMP])) |
                    (~alert_b_q & ~(st_rd | res_valid)));
      // read data captured at command time
      if (req.rd) begin
         unique case (req.addr)
            ADDR_RESULT: rd_data_d = temp16;
            ADDR_STATUS: rd_data_d = status_v;
            ADDR_CONV:   rd_data_d = conv_q & CONV_WMASK;
            ADDR_IRQEN:  rd_data_d = en_q & IRQEN_WMASK;
            ADDR_TLOW:   rd_data_d = tlow_q & TLOW_WMASK;
            default:     rd_data_d = 16'h0000;
         endcase
      end
      // soft reset returns control state to its reset values
      if (srst_go) begin
         conv_d    = CONV_RST;
         en_d      = IRQEN_RST;
         tlow_d    = TLOW_RST;
         dr_d      = 1'b0;
         crc_f_d   = 1'b0;
         sl_f_d    = 1'b0;
         hi_f_d    = 1'b0;
         lo_f_d    = 1'b0;
         hi_st_d   = 1'b0;
         lo_st_d   = 1'b0;
         alert_b_d = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         conv_q    <= CONV_RST;
         en_q      <= IRQEN_RST;
         tlow_q    <= TLOW_RST;
         dr_q      <= 1'b0;
         crc_f_q   <= 1'b0;
         sl_f_q    <= 1'b0;
         hi_f_q    <= 1'b0;
         lo_f_q    <= 1'b0;
         hi_st_q   <= 1'b0;
         lo_st_q   <= 1'b0;
         alert_b_q <= 1'b1;
         rd_data_q <= '0;
      end else begin
         conv_q    <= conv_d;
         en_q      <= en_d;
         tlow_q    <= tlow_d;
         dr_q      <= dr_d;
         crc_f_q   <= crc_f_d;
         sl_f_q    <= sl_f_d;
         hi_f_q    <= hi_f_d;
         lo_f_q    <= lo_f_d;
         hi_st_q   <= hi_st_d;
         lo_st_q   <= lo_st_d;
         alert_b_q <= alert_b_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign alert_b = alert_b_q;

   //////////////////////////////////////////////////////////////////////////
   // checks
   property p_conv_rd;
      @(posedge clk_sys) disable iff (!rst_b)
      req.rd && req.addr == ADDR_CONV |=> !rd_data_q[B_SRST] && !rd_data_q[B_ONESHOT];
   endproperty
   a_conv_rd: assert property (p_conv_rd) else $error("trigger bits read as one");

   property p_oneshot_stop;
      @(posedge clk_sys) disable iff (!rst_b)
      oneshot_done && !srst_go |=> conv_q[B_SHUTDOWN];
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop) else $error("no shutdown after one-shot");

   property p_tlow_lsb;
      @(posedge clk_sys) disable iff (!rst_b)
      req.rd && req.addr == ADDR_TLOW |=> rd_data_q[1:0] == 2'b00;
   endproperty
   a_tlow_lsb: assert property (p_tlow_lsb) else $error("low limit low bits not zero");

   property p_dr_alert;
      @(posedge clk_sys) disable iff (!rst_b)
      !conv_q[B_CMP] && en_q[0] && dr_q && !srst_go && !st_rd |=> !alert_b_q;
   endproperty
   a_dr_alert: assert property (p_dr_alert) else $error("enabled flag missed alert");

   property p_flag_sets;
      @(posedge clk_sys) disable iff (!rst_b)
      res_valid && !srst_go |=> dr_q;
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("data ready not set");

   property p_alert_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      !alert_b_q && !st_rd && !res_valid && !srst_go |=> !alert_b_q;
   endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("alert dropped early");

   property p_limit_skip;
      @(posedge clk_sys) disable iff (!rst_b)
      !limits_ok && !srst_go |=> $stable(hi_st_q) && $stable(lo_st_q);
   endproperty
   a_limit_skip: assert property (p_limit_skip) else $error("misordered limits used");

   property p_status_clr;
      @(posedge clk_sys) disable iff (!rst_b)
      st_rd && !res_valid && !crc_error && !slew_event
         |=> !crc_f_q && !sl_f_q && !hi_f_q && !lo_f_q && !dr_q;
   endproperty
   a_status_clr: assert property (p_status_clr) else $error("status read left flags");

   property p_tlow_rst;
      @(posedge clk_sys) disable iff (!rst_b)
      srst_go |=> tlow_q == TLOW_RST && en_q == IRQEN_RST ##1 srst_busy;
   endproperty
   a_tlow_rst: assert property (p_tlow_rst) else $error("soft reset values wrong");
endmodule : temp_sensor_config_alert_ctrl
